// *** verilog/cap_pkg.sv ***
`default_nettype none

package cap_pkg;

  // register offsets of the capability bank
  localparam logic [7:0] REG_CAP_ONE_LOW = 8'h24;
  localparam logic [7:0] REG_CAP_ONE_HIGH = 8'h25;
  localparam logic [7:0] REG_CAP_TWO_LOW = 8'h26;
  // value returned for any offset outside the bank
  localparam logic [7:0] READ_FILL = 8'h00;

  // index of each register inside the shadow array
  localparam logic [1:0] IDX_ONE_LOW = 2'h0;
  localparam logic [1:0] IDX_ONE_HIGH = 2'h1;
  localparam logic [1:0] IDX_TWO_LOW = 2'h2;
  localparam int CAP_COUNT = 3;

  // target address on the serial bus, value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] BIT_CNT_STEP = 4'h1;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // loader sequence after reset release
  localparam logic [2:0] LOAD_RESET = 3'h0;
  localparam logic [2:0] LOAD_STEP = 3'h1;
  localparam logic [2:0] LOAD_LATCH = 3'h2;
  localparam logic [2:0] LOAD_FIRST = 3'h3;
  localparam logic [2:0] LOAD_STORE = 3'h4;
  localparam logic [2:0] LOAD_DONE = 3'h6;

  // field encodings
  localparam logic [2:0] ROLE_SRC_CTRL = 3'h1;
  localparam logic [2:0] ROLE_SRC_PASS = 3'h7;
  localparam logic [1:0] PULLUP_ALL = 2'h2;
  localparam logic [1:0] PULLUP_NONE = 2'h3;
  localparam logic [1:0] ALARM_STEP_25MV = 2'h0;
  localparam logic [2:0] CABLE_PWR_1W5 = 3'h1;

  typedef struct packed {
    logic [2:0] power_role_support;
    logic debug_packet_support;
    logic cable_supply_source_support;
    logic sink_path_support;
    logic high_voltage_source_support;
    logic source_path_support;
  } cap_one_low_t;

  typedef struct packed {
    logic custom_target_support;
    logic overcurrent_report_support;
    logic overvoltage_report_support;
    logic bleed_discharge_support;
    logic forced_discharge_support;
    logic measure_alarm_support;
    logic [1:0] pullup_level_support;
  } cap_one_high_t;

  typedef struct packed {
    logic sink_disconnect_support;
    logic stop_discharge_threshold_support;
    logic [1:0] alarm_step_size;
    logic [2:0] cable_supply_power_level;
    logic cable_supply_fault_support;
  } cap_two_low_t;

  // nonvolatile contents, controller variant
  localparam cap_one_low_t ONE_LOW_CTRL = '{3'h1, 1'b1, 1'b1, 1'b0, 1'b1,
                                            1'b1};
  localparam cap_one_high_t ONE_HIGH_CTRL = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1,
                                              1'b1, 2'h2};
  // nonvolatile contents, pass-through variant
  localparam cap_one_low_t ONE_LOW_PASS = '{3'h7, 1'b0, 1'b1, 1'b0, 1'b1,
                                            1'b1};
  localparam cap_one_high_t ONE_HIGH_PASS = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1,
                                              1'b1, 2'h3};
  // shared by both variants
  localparam cap_two_low_t TWO_LOW_ALL = '{1'b0, 1'b1, 2'h0, 3'h1, 1'b1};

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WRITE = 7'h08,
    ST_WRITE_ACK = 7'h10,
    ST_READ = 7'h20,
    ST_READ_ACK = 7'h40
  } link_state_t;

endpackage : cap_pkg

`default_nettype wire

// *** verilog/cap_nvm.sv ***
`default_nettype none

module cap_nvm
  import cap_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_variant_pass,
  input wire logic i_rd_en,
  input wire logic [1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);

  // registered read of the fused capability words
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rd_data <= READ_FILL;
    end else if (i_rd_en) begin
      case (i_rd_addr)
        IDX_ONE_LOW: begin
          o_rd_data <= i_variant_pass ? ONE_LOW_PASS : ONE_LOW_CTRL;
        end
        IDX_ONE_HIGH: begin
          o_rd_data <= i_variant_pass ? ONE_HIGH_PASS : ONE_HIGH_CTRL;
        end
        IDX_TWO_LOW: begin
          o_rd_data <= TWO_LOW_ALL;
        end
        default: begin
          o_rd_data <= READ_FILL;
        end
      endcase
    end
  end

endmodule : cap_nvm

`default_nettype wire

// *** verilog/port_ctrl_capability_regs.sv ***
// Contract
// - three read-only 8-bit capability registers, nonvolatile
// - power role 001 controller, 111 pass-through
// - debug packet bit 1 controller, 0 pass-through
// - cable supply source bit reads 1
// - sink path bit reads 0
// - high voltage source bit reads 1
// - source path bit reads 1
// - custom target bit reads 1
// - overcurrent and overvoltage report bits read 1
// - measure alarm bit reads 1
// - pullup levels 10 controller, 11 pass-through
// - sink disconnect bit reads 0
// - stop discharge threshold bit reads 1
// - alarm step field reads 00
// - cable supply power field reads 001
// - cable supply fault bit reads 1
`default_nettype none

module port_ctrl_capability_regs
  import cap_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_variant_strap,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_caps_valid,
  output logic o_variant_pass
);

  logic scl_s1_q;
  logic scl_s2_q;
  logic scl_s3_q;
  logic sda_s1_q;
  logic sda_s2_q;
  logic sda_s3_q;
  logic strap_s1_q;
  logic strap_s2_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [2:0] load_cnt_q;
  logic variant_q;
  logic caps_valid_q;
  logic nvm_rd_en;
  logic [1:0] nvm_rd_addr;
  logic [7:0] nvm_rd_data;
  logic [CAP_COUNT-1:0][7:0] caps_q;
  link_state_t state_q;
  link_state_t state_d;
  logic [3:0] bit_cnt_q;
  logic byte_done;
  logic in_data;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic [7:0] read_byte;
  logic rw_q;
  logic first_q;
  logic host_nack_q;
  logic addr_match;
  logic sda_oe_q;

  // register lookup by offset
  function automatic logic [7:0] reg_read(
    input logic [7:0] ptr,
    input logic [CAP_COUNT-1:0][7:0] caps
  );
    logic [7:0] val;
    val = READ_FILL;
    case (ptr)
      REG_CAP_ONE_LOW: val = caps[IDX_ONE_LOW];
      REG_CAP_ONE_HIGH: val = caps[IDX_ONE_HIGH];
      REG_CAP_TWO_LOW: val = caps[IDX_TWO_LOW];
      default: val = READ_FILL;
    endcase
    return val;
  endfunction : reg_read

  // two-stage synchronisers for the pins, plus a history stage
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      scl_s1_q <= i_scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= i_sda;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      strap_s1_q <= i_variant_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  // bus events from the synchronised levels
  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // loader step counter, runs once after reset
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      load_cnt_q <= LOAD_RESET;
    end else if (load_cnt_q != LOAD_DONE) begin
      load_cnt_q <= load_cnt_q + LOAD_STEP;
    end
  end

  // variant strap caught once the synchroniser has settled
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      variant_q <= 1'b0;
    end else if (load_cnt_q == LOAD_LATCH) begin
      variant_q <= strap_s2_q;
    end
  end

  assign nvm_rd_en = (load_cnt_q >= LOAD_FIRST) && (load_cnt_q < LOAD_DONE);
  assign nvm_rd_addr = 2'(load_cnt_q - LOAD_FIRST);

  cap_nvm u_nvm (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_variant_pass(variant_q),
    .i_rd_en(nvm_rd_en),
    .i_rd_addr(nvm_rd_addr),
    .o_rd_data(nvm_rd_data)
  );

  // shadow copy of the nonvolatile words, frozen once loaded
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      caps_q <= '0;
      caps_valid_q <= 1'b0;
    end else if (!caps_valid_q && load_cnt_q >= LOAD_STORE) begin
      caps_q[2'(load_cnt_q - LOAD_STORE)] <= nvm_rd_data;
      caps_valid_q <= (load_cnt_q == LOAD_DONE);
    end
  end

  assign byte_done = (bit_cnt_q == BITS_PER_BYTE);
  assign addr_match = (rx_q[7:1] == DEV_ADDR);
  assign in_data = (state_q == ST_ADDR) || (state_q == ST_WRITE) ||
                   (state_q == ST_READ);
  assign read_byte = reg_read(ptr_q, caps_q);

  // link state transitions; bus ignored until the bank is loaded
  always_comb begin
    state_d = state_q;
    if (!caps_valid_q || bus_stop) begin
      state_d = ST_IDLE;
    end else if (bus_start) begin
      state_d = ST_ADDR;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_ADDR: begin
          if (scl_fall && byte_done) begin
            state_d = addr_match ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            state_d = rw_q ? ST_READ : ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (scl_fall && byte_done) begin
            state_d = ST_WRITE_ACK;
          end
        end
        ST_WRITE_ACK: begin
          if (scl_fall) begin
            state_d = ST_WRITE;
          end
        end
        ST_READ: begin
          if (scl_fall && byte_done) begin
            state_d = ST_READ_ACK;
          end
        end
        ST_READ_ACK: begin
          if (scl_fall) begin
            state_d = host_nack_q ? ST_IDLE : ST_READ;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // bit counter within a byte
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bit_cnt_q <= BIT_CNT_RESET;
    end else if (bus_start || bus_stop || (scl_fall && byte_done)) begin
      bit_cnt_q <= BIT_CNT_RESET;
    end else if (scl_rise && in_data) begin
      bit_cnt_q <= bit_cnt_q + BIT_CNT_STEP;
    end
  end

  // receive shifter, address and written bytes
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rx_q <= '0;
    end else if (scl_rise && ((state_q == ST_ADDR) ||
                              (state_q == ST_WRITE))) begin
      rx_q <= {rx_q[6:0], sda_s2_q};
    end
  end

  // direction and pointer-byte flags of the current transfer
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rw_q <= 1'b0;
      first_q <= 1'b0;
    end else if (state_q == ST_ADDR && scl_fall && byte_done) begin
      rw_q <= rx_q[0];
      first_q <= ~rx_q[0];
    end else if (state_q == ST_WRITE && scl_fall && byte_done) begin
      first_q <= 1'b0;
    end
  end

  // register pointer; data bytes only advance it
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ptr_q <= PTR_RESET;
    end else if (state_q == ST_WRITE && scl_fall && byte_done) begin
      ptr_q <= first_q ? rx_q : ptr_q + PTR_STEP;
    end else if (scl_fall && ((state_q == ST_ADDR_ACK && rw_q) ||
                              (state_q == ST_READ_ACK && !host_nack_q))) begin
      ptr_q <= ptr_q + PTR_STEP;
    end
  end

  // transmit shifter, loaded from the shadow bank
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      tx_q <= '0;
    end else if (scl_fall && ((state_q == ST_ADDR_ACK && rw_q) ||
                              (state_q == ST_READ_ACK && !host_nack_q))) begin
      tx_q <= read_byte;
    end else if (scl_fall && state_q == ST_READ && !byte_done) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // host acknowledge sampled on the ninth clock of a read byte
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      host_nack_q <= 1'b0;
    end else if (scl_rise && state_q == ST_READ_ACK) begin
      host_nack_q <= sda_s2_q;
    end
  end

  // open-drain data driver, changes on falling clock, released at start or stop
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sda_oe_q <= 1'b0;
    end else if (!caps_valid_q || bus_start || bus_stop) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: sda_oe_q <= byte_done && addr_match;
        ST_ADDR_ACK: sda_oe_q <= rw_q && !read_byte[7];
        ST_WRITE: sda_oe_q <= byte_done;
        ST_WRITE_ACK: sda_oe_q <= 1'b0;
        ST_READ: sda_oe_q <= !byte_done && !tx_q[6];
        ST_READ_ACK: sda_oe_q <= !host_nack_q && !read_byte[7];
        default: sda_oe_q <= 1'b0;
      endcase
    end
  end

  // outputs straight from flip-flops
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      o_caps_valid <= 1'b0;
      o_variant_pass <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
      o_sda_oe <= sda_oe_q;
      o_caps_valid <= caps_valid_q;
      o_variant_pass <= variant_q;
    end
  end

  // field views used by the checks below
  cap_one_low_t one_low_v;
  cap_one_high_t one_high_v;
  cap_two_low_t two_low_v;
  assign one_low_v = cap_one_low_t'(caps_q[IDX_ONE_LOW]);
  assign one_high_v = cap_one_high_t'(caps_q[IDX_ONE_HIGH]);
  assign two_low_v = cap_two_low_t'(caps_q[IDX_TWO_LOW]);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_read_load;
    scl_fall && state_q == ST_ADDR_ACK && rw_q;
  endsequence
  sequence s_write_data;
    scl_fall && state_q == ST_WRITE && byte_done && !first_q;
  endsequence

  a_bank_loaded: assert property (
    $rose(caps_valid_q) |-> load_cnt_q == LOAD_DONE ##1 o_caps_valid)
    else $error("capability bank load timing wrong");
  a_read_source: assert property (
    s_read_load |=> tx_q == reg_read($past(ptr_q), caps_q))
    else $error("read byte not taken from bank");
  a_role_field: assert property (
    caps_valid_q |-> one_low_v.power_role_support ==
      (variant_q ? ROLE_SRC_PASS : ROLE_SRC_CTRL))
    else $error("power role field wrong");
  a_debug_bit: assert property (
    caps_valid_q |-> one_low_v.debug_packet_support == !variant_q)
    else $error("debug packet bit wrong");
  a_cable_source: assert property (
    caps_valid_q |-> one_low_v.cable_supply_source_support)
    else $error("cable supply source bit wrong");
  a_sink_path: assert property (
    caps_valid_q |-> !one_low_v.sink_path_support)
    else $error("sink path bit wrong");
  a_high_voltage: assert property (
    caps_valid_q |-> one_low_v.high_voltage_source_support)
    else $error("high voltage bit wrong");
  a_source_path: assert property (
    caps_valid_q |-> one_low_v.source_path_support)
    else $error("source path bit wrong");
  a_custom_target: assert property (
    caps_valid_q |-> one_high_v.custom_target_support)
    else $error("custom target bit wrong");
  a_fault_report: assert property (
    caps_valid_q |-> one_high_v.overcurrent_report_support &&
      one_high_v.overvoltage_report_support)
    else $error("fault report bits wrong");
  a_measure_alarm: assert property (
    caps_valid_q |-> one_high_v.measure_alarm_support)
    else $error("measure alarm bit wrong");
  a_pullup_field: assert property (
    caps_valid_q |-> one_high_v.pullup_level_support ==
      (variant_q ? PULLUP_NONE : PULLUP_ALL))
    else $error("pullup level field wrong");
  a_sink_disconnect: assert property (
    caps_valid_q |-> !two_low_v.sink_disconnect_support)
    else $error("sink disconnect bit wrong");
  a_stop_threshold: assert property (
    caps_valid_q |-> two_low_v.stop_discharge_threshold_support)
    else $error("stop discharge bit wrong");
  a_alarm_step: assert property (
    caps_valid_q |-> two_low_v.alarm_step_size == ALARM_STEP_25MV)
    else $error("alarm step field wrong");
  a_cable_power: assert property (
    caps_valid_q |-> two_low_v.cable_supply_power_level == CABLE_PWR_1W5)
    else $error("cable supply power field wrong");
  a_cable_fault: assert property (
    caps_valid_q |-> two_low_v.cable_supply_fault_support)
    else $error("cable supply fault bit wrong");
  a_write_ignored: assert property (
    s_write_data |=> $stable(caps_q) ##1 $stable(caps_q))
    else $error("write altered capability bank");
  a_bank_frozen: assert property (
    caps_valid_q |=> caps_valid_q && $stable(caps_q) && $stable(variant_q))
    else $error("capability bank changed after load");

endmodule : port_ctrl_capability_regs

`default_nettype wire

// *** tb/host_model.sv ***
`default_nettype none

module host_model
  import cap_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_drv,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF = 8;

  // idle bus: clock stands high, data released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_drv = 1'b1;
    o_rd_valid = 1'b0;
    o_rd_data = 8'h00;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wait_clk

  // one bit: data set mid-low, sampled mid-high, clock never runs free
  task automatic bit_xfer(input logic b, output logic r);
    wait_clk(4);
    o_sda_drv <= b;
    wait_clk(HALF);
    o_scl <= 1'b1;
    wait_clk(HALF / 2);
    r = i_sda;
    wait_clk(HALF / 2);
    o_scl <= 1'b0;
  endtask : bit_xfer

  // start or repeated start: data falls while clock high
  task automatic start_cond();
    wait_clk(4);
    o_sda_drv <= 1'b1;
    wait_clk(HALF);
    o_scl <= 1'b1;
    wait_clk(HALF);
    o_sda_drv <= 1'b0;
    wait_clk(HALF);
    o_scl <= 1'b0;
  endtask : start_cond

  // stop: data rises while clock high, bus left idle
  task automatic stop_cond();
    wait_clk(4);
    o_sda_drv <= 1'b0;
    wait_clk(HALF);
    o_scl <= 1'b1;
    wait_clk(HALF);
    o_sda_drv <= 1'b1;
    wait_clk(HALF);
  endtask : stop_cond

  // byte out msb first, then the target's acknowledge slot
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  // byte in msb first, reported as a one-cycle pulse, then ack or nack
  task automatic rd_byte(input logic more);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    o_rd_data <= d;
    o_rd_valid <= 1'b1;
    wait_clk(1);
    o_rd_valid <= 1'b0;
    bit_xfer(~more, r);
  endtask : rd_byte
endmodule : host_model

`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none

module testbench
  import cap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk;
  logic i_reset_n;
  logic i_variant_strap;
  logic scl, sda_drv, sda_oe, sda_out, caps_valid, variant_pass, rd_valid;
  logic [7:0] rd_data;
  wire logic sda_w;
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 77800;

  // open-drain data wire with pull-up
  assign sda_w = (sda_oe ? sda_out : 1'b1) & sda_drv;

  port_ctrl_capability_regs dut_u (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_scl(scl),
    .i_sda(sda_w),
    .i_variant_strap(i_variant_strap),
    .o_sda_out(sda_out),
    .o_sda_oe(sda_oe),
    .o_caps_valid(caps_valid),
    .o_variant_pass(variant_pass)
  );

  host_model host_u (
    .i_clk(i_clk),
    .i_sda(sda_w),
    .o_scl(scl),
    .o_sda_drv(sda_drv),
    .o_rd_valid(rd_valid),
    .o_rd_data(rd_data)
  );

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // expected contents built field by field, outside the bank reads zero
  function automatic logic [7:0] exp_reg(input logic [7:0] p,
                                         input logic pass);
    case (p)
      8'h24: exp_reg = {pass ? 3'h7 : 3'h1, ~pass,
                        4'hB};
      8'h25: exp_reg = {6'h3B,
                        pass ? 2'h3 : 2'h2};
      8'h26: exp_reg = {1'b0, 1'b1, 2'h0,
                        3'h1, 1'b1};
      default: exp_reg = 8'h00;
    endcase
  endfunction : exp_reg

  // reset with a given strap, then wait for the bank to load
  task automatic do_reset(input logic pass);
    i_reset_n <= 1'b0;
    i_variant_strap <= pass;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int i = 0; i < 50 && caps_valid !== 1'b1; i++) begin
      @(posedge i_clk);
    end
    check({7'h00, caps_valid}, 8'h01);
    check({7'h00, variant_pass}, {7'h00, pass});
  endtask : do_reset

  // address phase with pointer byte, acks checked
  task automatic set_ptr(input logic [7:0] p);
    logic ack;
    host_u.start_cond();
    host_u.wr_byte({DEV_ADDR, 1'b0}, ack);
    check({7'h00, ack}, 8'h01);
    host_u.wr_byte(p, ack);
    check({7'h00, ack}, 8'h01);
  endtask : set_ptr

  // burst read from a pointer, each byte noted in the queue
  task automatic read_seq(input logic [7:0] p, input int n, input logic pass);
    logic ack;
    set_ptr(p);
    host_u.start_cond();
    host_u.wr_byte({DEV_ADDR, 1'b1}, ack);
    check({7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(exp_reg(p + i[7:0], pass));
      host_u.rd_byte(i < n - 1);
    end
    host_u.stop_cond();
  endtask : read_seq

  // random data written over the bank, acked but discarded
  task automatic write_seq(input logic [7:0] p, input int n);
    logic ack;
    logic [7:0] d;
    set_ptr(p);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      host_u.wr_byte(d, ack);
      check({7'h00, ack}, 8'h01);
    end
    host_u.stop_cond();
  endtask : write_seq

  // result watcher: each byte seen is compared with the oldest note
  always @(posedge i_clk) begin
    if (rd_valid === 1'b1) begin
      check({7'h00, exp_q.size() != 0}, 8'h01);
      if (exp_q.size() != 0) begin
        check(rd_data, exp_q.pop_front());
      end
    end
  end

  initial begin
    logic ack;
    logic [7:0] off;
    i_reset_n = 1'b0;
    i_variant_strap = 1'b0;
    @(posedge i_clk);
    do_reset(1'b0);
    read_seq(8'h24, 3, 1'b0);
    read_seq(8'h23, 5, 1'b0);
    write_seq(8'h24, 3);
    read_seq(8'h24, 3, 1'b0);
    // foreign address is left unanswered
    host_u.start_cond();
    host_u.wr_byte({DEV_ADDR ^ 7'h01, 1'b1}, ack);
    check({7'h00, ack}, 8'h00);
    host_u.stop_cond();
    for (int k = 0; k < 3; k++) begin
      off = 8'h27 + (8'($random(seed)) & 8'h3F);
      read_seq(off, 2, 1'b0);
    end
    read_seq(8'hFF, 2, 1'b0);
    // second reset mid-run selects the pass-through contents
    do_reset(1'b1);
    read_seq(8'h24, 3, 1'b1);
    write_seq(8'h25, 2);
    read_seq(8'h24, 3, 1'b1);
    repeat (20) @(posedge i_clk);
    check(8'(exp_q.size()), 8'h00);
    end_sim();
  end

  // hang guard well beyond the expected run length
  initial begin
    repeat (60000) @(posedge i_clk);
    n_mismatch++;
    end_sim();
  end
endmodule : testbench

`default_nettype wire
